// ### lu_pkg.sv
// shared constants, opcodes and carrier structs for the load unit
package lu_pkg;
  // instruction field positions
  localparam int MAJOR_HI = 31;
  localparam int MAJOR_LO = 30;
  localparam int RD_HI = 29;
  localparam int RD_LO = 25;
  localparam int OPC_HI = 24;
  localparam int OPC_LO = 19;
  localparam int SRC1_HI = 18;
  localparam int SRC1_LO = 14;
  localparam int IMM_SEL_BIT = 13;
  localparam int ASI_HI = 12;
  localparam int ASI_LO = 5;
  localparam int SRC2_HI = 4;
  localparam int SRC2_LO = 0;
  localparam int SIMM_HI = 12;
  localparam logic [1:0] MAJOR_MEM = 2'h3;
  // operation codes
  localparam logic [5:0] OPC_LDSB = 6'h09;
  localparam logic [5:0] OPC_LDSH = 6'h0A;
  localparam logic [5:0] OPC_LDUB = 6'h01;
  localparam logic [5:0] OPC_LDUH = 6'h02;
  localparam logic [5:0] OPC_LDW = 6'h00;
  localparam logic [5:0] OPC_LDDW = 6'h03;
  localparam logic [5:0] OPC_LDSBA = 6'h19;
  localparam logic [5:0] OPC_LDSHA = 6'h1A;
  localparam logic [5:0] OPC_LDUBA = 6'h11;
  localparam logic [5:0] OPC_LDUHA = 6'h12;
  localparam logic [5:0] OPC_LDWA = 6'h10;
  localparam logic [5:0] OPC_LDDWA = 6'h13;
  localparam logic [5:0] OPC_FSGL = 6'h20;
  localparam logic [5:0] OPC_FDBL = 6'h23;
  localparam logic [5:0] OPC_FSTATE = 6'h21;
  localparam logic [5:0] OPC_CSGL = 6'h30;
  localparam logic [5:0] OPC_CDBL = 6'h33;
  localparam logic [5:0] OPC_CSTATE = 6'h31;
  // space identifiers for non-alternate loads
  localparam logic [7:0] ASI_USER_DATA = 8'h0A;
  localparam logic [7:0] ASI_SUPER_DATA = 8'h0B;
  // trap codes
  localparam logic [3:0] TRAP_NONE = 4'h0;
  localparam logic [3:0] TRAP_ILLEGAL = 4'h1;
  localparam logic [3:0] TRAP_PRIV = 4'h2;
  localparam logic [3:0] TRAP_MISALIGN = 4'h3;
  localparam logic [3:0] TRAP_FP_DIS = 4'h4;
  localparam logic [3:0] TRAP_FP_EXC = 4'h5;
  localparam logic [3:0] TRAP_CP_DIS = 4'h6;
  localparam logic [3:0] TRAP_DATA_EXC = 4'h7;
  localparam logic [2:0] BAD_FLOAT_REGISTER_CODE = 3'h6;
  localparam logic [2:0] FTT_NONE = 3'h0;
  // constant written to float targets on an access fault
  localparam logic [31:0] FLOAT_FAULT_FILL = 32'hFFFFFFFF;
  localparam logic [2:0] LOCK_HOLD_CYCLES = 3'h3;
  localparam logic [1:0] DEST_INT = 2'h0;
  localparam logic [1:0] DEST_FLOAT = 2'h1;
  localparam logic [1:0] DEST_FSTATE = 2'h2;
  localparam logic [1:0] DEST_COPROC = 2'h3;
  // memory request towards the data memory system
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] asi;
    logic lock;
  } lu_mem_req_s;
  // register write-back towards the core
  typedef struct packed {
    logic [1:0] file;
    logic [4:0] num;
    logic [31:0] data;
  } lu_wb_s;
endpackage

// ### lu_load_unit.sv
// load instruction decode, checking, memory sequencing and write-back
// Operation
// - decode signed byte/halfword loads, plain and alternate
// - decode unsigned byte/halfword loads, plain and alternate
// - decode word and doubleword loads, plain and alternate
// - decode float single, pair, state loads
// - decode coprocessor single, pair, state loads
// - address is source plus source or immediate
// - narrow data right-justified, sign or zero filled
// - doubleword fills even then odd register
// - odd doubleword destination gives illegal trap
// - alternate space uses field; immediate is illegal
// - alternate loads privileged outside supervisor
// - plain loads use user or system space
// - every load is one atomic locked access
// - integer alignment checks by size, bytes unchecked
// - first word may be written before trap
// - float pair fills even then odd register
// - odd float pair gives float exception trap
// - state load waits for float unit idle
// - branch condition after state load undefined
// - float alignment checks, word or doubleword
// - float disabled or absent gives disabled trap
// - float single or pair fault fills the faulting word's target with fixed constant
`timescale 1ns/1ps
`default_nettype none
module lu_load_unit (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_issue, // instruction presented this cycle
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_src1_val, // first source register value
  input wire logic [31:0] i_src2_val, // second source register value
  input wire logic i_supervisor, // supervisor bit of state register
  input wire logic i_float_enable_bit,
  input wire logic i_float_present,
  input wire logic i_coproc_enable,
  input wire logic i_coproc_present,
  input wire logic i_float_busy, // float operates still running
  input wire logic i_mem_ready, // memory answer valid
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_mem_fault, // data access exception
  output logic o_busy,
  output logic o_mem_valid,
  output lu_pkg::lu_mem_req_s o_mem_req,
  output logic o_wb_valid,
  output lu_pkg::lu_wb_s o_wb,
  output logic o_trap_valid,
  output logic [3:0] o_trap_code,
  output logic [2:0] o_float_trap_type,
  output logic o_done,
  output logic o_fcc_undefined // float condition not yet reliable
);
  // sequencer states: idle, float drain, first word, second word
  // only one load is ever in flight, so no queue of contexts is kept
  // the second word state is reached only by pair loads
  typedef enum {ST_IDLE, ST_WAIT_FLOAT, ST_FIRST, ST_SECOND} lu_state_e;

  // decoded view of one load
  typedef struct packed {
    logic valid;
    logic is_alt;
    logic is_signed;
    logic [1:0] size_log; // 0 byte, 1 half, 2 word, 3 double
    logic [1:0] file;
  } lu_dec_s;

  // operation code to load class
  function automatic lu_dec_s decode_op(input logic [5:0] opc);
    lu_dec_s d;
    d = '0;
    d.valid = 1'b1;
    d.file = lu_pkg::DEST_INT;
    case (opc)
      lu_pkg::OPC_LDSB, lu_pkg::OPC_LDSBA: begin
        d.is_signed = 1'b1;
        d.size_log = 2'h0;
      end
      lu_pkg::OPC_LDSH, lu_pkg::OPC_LDSHA: begin
        d.is_signed = 1'b1;
        d.size_log = 2'h1;
      end
      lu_pkg::OPC_LDUB, lu_pkg::OPC_LDUBA: d.size_log = 2'h0;
      lu_pkg::OPC_LDUH, lu_pkg::OPC_LDUHA: d.size_log = 2'h1;
      lu_pkg::OPC_LDW, lu_pkg::OPC_LDWA: d.size_log = 2'h2;
      lu_pkg::OPC_LDDW, lu_pkg::OPC_LDDWA: d.size_log = 2'h3;
      lu_pkg::OPC_FSGL: begin
        d.size_log = 2'h2;
        d.file = lu_pkg::DEST_FLOAT;
      end
      lu_pkg::OPC_FDBL: begin
        d.size_log = 2'h3;
        d.file = lu_pkg::DEST_FLOAT;
      end
      lu_pkg::OPC_FSTATE: begin
        d.size_log = 2'h2;
        d.file = lu_pkg::DEST_FSTATE;
      end
      lu_pkg::OPC_CSGL, lu_pkg::OPC_CSTATE: begin
        d.size_log = 2'h2;
        d.file = lu_pkg::DEST_COPROC;
      end
      lu_pkg::OPC_CDBL: begin
        d.size_log = 2'h3;
        d.file = lu_pkg::DEST_COPROC;
      end
      default: d.valid = 1'b0;
    endcase
    // alternate forms have bit 4 of the code set in the integer group
    d.is_alt = d.valid && (opc[5:4] == 2'h1);
    return d;
  endfunction

  // field extraction
  logic [1:0] major;
  logic [4:0] rd_field;
  logic [5:0] operation_code_field;
  logic imm_sel;
  logic [7:0] asi_field;
  logic [31:0] signed_immediate_field;
  lu_dec_s dec;
  assign major = i_instr[lu_pkg::MAJOR_HI:lu_pkg::MAJOR_LO];
  assign rd_field = i_instr[lu_pkg::RD_HI:lu_pkg::RD_LO];
  assign operation_code_field = i_instr[lu_pkg::OPC_HI:lu_pkg::OPC_LO];
  assign imm_sel = i_instr[lu_pkg::IMM_SEL_BIT];
  assign asi_field = i_instr[lu_pkg::ASI_HI:lu_pkg::ASI_LO];
  assign signed_immediate_field = {{19{i_instr[lu_pkg::SIMM_HI]}},
    i_instr[lu_pkg::SIMM_HI:0]};
  assign dec = decode_op(operation_code_field);

  // effective address
  // wraps modulo 2^32; overflow is not a fault
  // immediate form ignores the second source value entirely
  logic [31:0] eff_addr;
  assign eff_addr = i_src1_val +
    (imm_sel ? signed_immediate_field : i_src2_val);

  // trap checks in priority order
  // every check uses the issue-cycle view of the instruction
  // a trapped load never reaches memory, so nothing is half done
  // only a data fault on a pair's second word, or on any word of a float single or pair load, leaves partial state
  logic misaligned;
  logic [3:0] issue_trap;
  logic [2:0] issue_ftt;
  always_comb begin
    case (dec.size_log)
      2'h0: misaligned = 1'b0;
      2'h1: misaligned = eff_addr[0];
      2'h2: misaligned = |eff_addr[1:0];
      default: misaligned = |eff_addr[2:0];
    endcase
  end
  always_comb begin
    issue_trap = lu_pkg::TRAP_NONE;
    issue_ftt = lu_pkg::FTT_NONE;
    if (major != lu_pkg::MAJOR_MEM || !dec.valid) begin
      issue_trap = lu_pkg::TRAP_ILLEGAL;
    end else if (dec.is_alt && imm_sel) begin
      issue_trap = lu_pkg::TRAP_ILLEGAL;
    end else if (dec.is_alt && !i_supervisor) begin
      issue_trap = lu_pkg::TRAP_PRIV;
    end else if ((dec.file == lu_pkg::DEST_FLOAT ||
      dec.file == lu_pkg::DEST_FSTATE) &&
      (!i_float_enable_bit || !i_float_present)) begin
      issue_trap = lu_pkg::TRAP_FP_DIS;
    end else if (dec.file == lu_pkg::DEST_COPROC &&
      (!i_coproc_enable || !i_coproc_present)) begin
      issue_trap = lu_pkg::TRAP_CP_DIS;
    end else if (dec.file == lu_pkg::DEST_INT && dec.size_log == 2'h3 &&
      rd_field[0]) begin
      issue_trap = lu_pkg::TRAP_ILLEGAL;
    end else if (dec.file == lu_pkg::DEST_FLOAT && dec.size_log == 2'h3 &&
      rd_field[0]) begin
      issue_trap = lu_pkg::TRAP_FP_EXC;
      issue_ftt = lu_pkg::BAD_FLOAT_REGISTER_CODE;
    end else if (misaligned) begin
      issue_trap = lu_pkg::TRAP_MISALIGN;
    end
  end

  // captured load context
  lu_state_e state_q;
  logic [31:0] addr_q;
  logic [7:0] asi_q;
  logic [4:0] rd_q;
  lu_dec_s dec_q;
  logic accept;
  assign accept = i_issue && state_q == ST_IDLE &&
    issue_trap == lu_pkg::TRAP_NONE;

  // sequencer
  // a new issue is taken only in idle; issues while busy are dropped
  // a fault on the first word ends the load at once
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && dec.file == lu_pkg::DEST_FSTATE) begin
            state_q <= ST_WAIT_FLOAT;
          end else if (accept) begin
            state_q <= ST_FIRST;
          end
        end
        ST_WAIT_FLOAT: begin
          if (!i_float_busy) begin
            state_q <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (i_mem_ready && !i_mem_fault && dec_q.size_log == 2'h3) begin
            state_q <= ST_SECOND;
          end else if (i_mem_ready) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SECOND: begin
          if (i_mem_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // context capture; the second word goes to address plus four
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      addr_q <= 32'h00000000;
      asi_q <= 8'h00;
      rd_q <= 5'h00;
      dec_q <= '0;
    end else if (accept) begin
      addr_q <= eff_addr;
      rd_q <= rd_field;
      dec_q <= dec;
      if (dec.is_alt) begin
        asi_q <= asi_field;
      end else if (i_supervisor) begin
        asi_q <= lu_pkg::ASI_SUPER_DATA;
      end else begin
        asi_q <= lu_pkg::ASI_USER_DATA;
      end
    end else if (state_q == ST_FIRST && i_mem_ready) begin
      addr_q <= addr_q + 32'h00000004;
    end
  end

  // memory request; lock held across both words of a pair
  // request fields come from flip-flops and stay put until ready
  // lock keeps other masters out between the two words
  assign o_mem_valid = (state_q == ST_FIRST) || (state_q == ST_SECOND);
  assign o_mem_req.addr = addr_q;
  assign o_mem_req.asi = asi_q;
  assign o_mem_req.lock = o_mem_valid;
  assign o_busy = state_q != ST_IDLE;

  // byte lane steering and extension, big-endian lanes
  // lane 0 sits in the top byte of the memory word
  // words and pairs pass through unchanged
  logic [31:0] load_data;
  always_comb begin
    case (dec_q.size_log)
      2'h0: begin
        case (addr_q[1:0])
          2'h0: load_data = {24'h000000, i_mem_rdata[31:24]};
          2'h1: load_data = {24'h000000, i_mem_rdata[23:16]};
          2'h2: load_data = {24'h000000, i_mem_rdata[15:8]};
          default: load_data = {24'h000000, i_mem_rdata[7:0]};
        endcase
        if (dec_q.is_signed) begin
          load_data[31:8] = {24{load_data[7]}};
        end
      end
      2'h1: begin
        load_data = addr_q[1] ? {16'h0000, i_mem_rdata[15:0]} :
          {16'h0000, i_mem_rdata[31:16]};
        if (dec_q.is_signed) begin
          load_data[31:16] = {16{load_data[15]}};
        end
      end
      default: load_data = i_mem_rdata;
    endcase
  end

  // write-back, traps and completion
  // all three are one-cycle pulses; payload fields hold until reused
  // done marks only the last word of a successful load
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_wb_valid <= 1'b0;
      o_wb <= '0;
      o_trap_valid <= 1'b0;
      o_trap_code <= lu_pkg::TRAP_NONE;
      o_float_trap_type <= lu_pkg::FTT_NONE;
      o_done <= 1'b0;
    end else begin
      o_wb_valid <= 1'b0;
      o_trap_valid <= 1'b0;
      o_done <= 1'b0;
      if (state_q == ST_IDLE && i_issue &&
        issue_trap != lu_pkg::TRAP_NONE) begin
        o_trap_valid <= 1'b1;
        o_trap_code <= issue_trap;
        o_float_trap_type <= issue_ftt;
      end else if ((state_q == ST_FIRST || state_q == ST_SECOND) &&
        i_mem_ready) begin
        o_wb.file <= dec_q.file;
        // pair: even register first, then odd one
        o_wb.num <= (state_q == ST_SECOND) ? (rd_q | 5'h01) :
          (dec_q.size_log == 2'h3 ? (rd_q & 5'h1E) : rd_q);
        if (i_mem_fault) begin
          // earlier first word of a pair stays written
          o_trap_valid <= 1'b1;
          o_trap_code <= lu_pkg::TRAP_DATA_EXC;
          o_float_trap_type <= lu_pkg::FTT_NONE;
          o_wb.data <= lu_pkg::FLOAT_FAULT_FILL;
          o_wb_valid <= dec_q.file == lu_pkg::DEST_FLOAT;
        end else begin
          o_wb.data <= load_data;
          // integer write to register zero is dropped by the core
          o_wb_valid <= 1'b1;
          o_done <= state_q == ST_SECOND || dec_q.size_log != 2'h3;
        end
      end
    end
  end

  // hold-off window after a state register load
  // counts issued instructions, not clock cycles
  // a user must not trust the branch condition while this is set
  logic [2:0] fcc_count_q;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fcc_count_q <= 3'h0;
    end else if (o_done && dec_q.file == lu_pkg::DEST_FSTATE) begin
      fcc_count_q <= lu_pkg::LOCK_HOLD_CYCLES;
    end else if (fcc_count_q != 3'h0 && i_issue) begin
      fcc_count_q <= fcc_count_q - 3'h1;
    end
  end
  assign o_fcc_undefined = fcc_count_q != 3'h0;
endmodule
`default_nettype wire

// ### lu_monitor.sv
// assertion checker bound to the load unit ports
`timescale 1ns/1ps
`default_nettype none
module lu_monitor (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_issue,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_src1_val,
  input wire logic [31:0] i_src2_val,
  input wire logic i_supervisor,
  input wire logic i_float_enable_bit,
  input wire logic i_float_busy,
  input wire logic i_mem_ready,
  input wire logic o_busy,
  input wire logic o_mem_valid,
  input wire lu_pkg::lu_mem_req_s o_mem_req,
  input wire logic o_trap_valid,
  input wire logic [3:0] o_trap_code,
  input wire logic o_done,
  input wire logic o_fcc_undefined
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic take; // memory-format instruction issued while idle
  logic [5:0] opc; // operation code field
  logic [1:0] lo; // low address bits, register form
  logic [5:0] op_q; // code of the load in flight
  logic sup_q; // supervisor bit at accept
  assign take = i_issue && !o_busy && i_instr[31:30] == lu_pkg::MAJOR_MEM;
  assign opc = i_instr[24:19];
  assign lo = i_src1_val[1:0] + i_src2_val[1:0];
  // remember what the unit is working on
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      op_q <= 6'h00;
      sup_q <= 1'b0;
    end else if (take) begin
      op_q <= opc;
      sup_q <= i_supervisor;
    end
  end
  property p_lock; o_mem_valid |-> o_mem_req.lock; endproperty
  a_lock: assert property (p_lock) else $error("unlocked access");
  property p_hold; o_mem_valid && !i_mem_ready |=>
    o_mem_valid && $stable(o_mem_req); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_alt_imm; take && opc == lu_pkg::OPC_LDWA && i_instr[13] |=>
    o_trap_valid && o_trap_code == lu_pkg::TRAP_ILLEGAL; endproperty
  a_alt_imm: assert property (p_alt_imm) else $error("alt imm");
  property p_priv; take && opc == lu_pkg::OPC_LDWA && !i_instr[13] &&
    !i_supervisor |=> o_trap_valid && o_trap_code == lu_pkg::TRAP_PRIV;
  endproperty
  a_priv: assert property (p_priv) else $error("user alt load");
  property p_fp_off; take && opc == lu_pkg::OPC_FSGL && !i_float_enable_bit
    |=> o_trap_valid && o_trap_code == lu_pkg::TRAP_FP_DIS; endproperty
  a_fp_off: assert property (p_fp_off) else $error("float off");
  property p_odd; take && opc == lu_pkg::OPC_LDDW && i_instr[25] |=>
    o_trap_valid && o_trap_code == lu_pkg::TRAP_ILLEGAL; endproperty
  a_odd: assert property (p_odd) else $error("odd pair");
  property p_align; take && opc == lu_pkg::OPC_LDW && !i_instr[13] &&
    lo != 2'h0 |=> o_trap_valid && o_trap_code == lu_pkg::TRAP_MISALIGN;
  endproperty
  a_align: assert property (p_align) else $error("misaligned word");
  property p_space; o_mem_valid && op_q == lu_pkg::OPC_LDW |-> o_mem_req.asi
    == (sup_q ? lu_pkg::ASI_SUPER_DATA : lu_pkg::ASI_USER_DATA); endproperty
  a_space: assert property (p_space) else $error("wrong space");
  property p_fs_wait; o_mem_valid && op_q == lu_pkg::OPC_FSTATE |->
    !$past(i_float_busy); endproperty
  a_fs_wait: assert property (p_fs_wait) else $error("float busy");
  property p_fcc; o_done && op_q == lu_pkg::OPC_FSTATE |=> o_fcc_undefined;
  endproperty
  a_fcc: assert property (p_fcc) else $error("fcc not flagged");
endmodule
bind lu_load_unit lu_monitor MON (.i_clock(i_clock), .i_rst(i_rst),
  .i_issue(i_issue), .i_instr(i_instr), .i_src1_val(i_src1_val),
  .i_src2_val(i_src2_val), .i_supervisor(i_supervisor),
  .i_float_enable_bit(i_float_enable_bit), .i_float_busy(i_float_busy),
  .i_mem_ready(i_mem_ready), .o_busy(o_busy), .o_mem_valid(o_mem_valid),
  .o_mem_req(o_mem_req), .o_trap_valid(o_trap_valid),
  .o_trap_code(o_trap_code), .o_done(o_done),
  .o_fcc_undefined(o_fcc_undefined));
`default_nettype wire

// ### lu_mem_model.sv
// data memory stand-in answering load requests
`timescale 1ns/1ps
`default_nettype none
module lu_mem_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_valid, // request from the unit
  input wire lu_pkg::lu_mem_req_s i_req,
  input wire logic i_slow, // answer three cycles later
  input wire logic i_fault_en, // fault the word at i_fault_addr
  input wire logic [31:0] i_fault_addr,
  output logic o_ready,
  output logic [31:0] o_rdata,
  output logic o_fault
);
  logic [1:0] wait_q; // cycles left before answering
  logic ans; // answer launched at this edge
  assign ans = i_valid && !o_ready && wait_q == 2'h0;
  // one answer pulse per request
  always_ff @(posedge i_clock) begin
    if (i_rst || !i_valid || o_ready) begin
      o_ready <= 1'b0;
      o_fault <= 1'b0;
      wait_q <= i_slow ? 2'h3 : 2'h0;
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      o_ready <= 1'b1;
      o_fault <= i_fault_en && i_req.addr[31:2] == i_fault_addr[31:2];
    end
  end
  // word follows its address; stale data flips so nothing is reused
  always_ff @(posedge i_clock) begin
    if (i_rst) o_rdata <= 32'h5A5A5A5A;
    else if (ans) o_rdata <= {i_req.addr[31:2], 2'h0} * 32'h00009E37 + 32'h1357;
    else o_rdata <= ~o_rdata;
  end
endmodule
`default_nettype wire

// ### lu_load_unit_tb.sv
// self-checking bench for the load unit with a reference model
`timescale 1ns/1ps
`default_nettype none
module lu_load_unit_tb;
  logic clk = 1'b0, rst = 1'b1, issue = 1'b0, sup = 1'b1, fen = 1'b1;
  logic fpres = 1'b1, fbusy = 1'b0, slow = 1'b0, fault_en = 1'b0;
  logic [31:0] fault_addr = 32'h0, instr = 32'h0, src1 = 32'h0, src2 = 32'h0;
  logic [31:0] seed = 32'h0000004F; // xorshift state
  logic ready, fault, busy, mvalid, wbv, trapv, done, fccu;
  logic [31:0] rdata;
  logic [3:0] tcode;
  logic [2:0] ftt;
  lu_pkg::lu_mem_req_s req;
  lu_pkg::lu_wb_s wb;
  logic [38:0] expq[$]; // expected write-backs in order
  int errors = 0;
  int checks = 0;
  logic [5:0] ops[19] = '{6'h09, 6'h0A, 6'h01, 6'h02, 6'h00, 6'h03, 6'h19,
    6'h1A, 6'h11, 6'h12, 6'h10, 6'h13, 6'h20, 6'h23, 6'h21, 6'h30, 6'h33,
    6'h31, 6'h3F};
  lu_load_unit DUT (.i_clock(clk), .i_rst(rst), .i_issue(issue),
    .i_instr(instr), .i_src1_val(src1), .i_src2_val(src2), .i_supervisor(sup),
    .i_float_enable_bit(fen), .i_float_present(fpres),
    .i_coproc_enable(1'b0), .i_coproc_present(1'b0), .i_float_busy(fbusy),
    .i_mem_ready(ready), .i_mem_rdata(rdata), .i_mem_fault(fault),
    .o_busy(busy), .o_mem_valid(mvalid), .o_mem_req(req), .o_wb_valid(wbv),
    .o_wb(wb), .o_trap_valid(trapv), .o_trap_code(tcode),
    .o_float_trap_type(ftt), .o_done(done), .o_fcc_undefined(fccu));
  lu_mem_model MEM (.i_clock(clk), .i_rst(rst), .i_valid(mvalid),
    .i_req(req), .i_slow(slow), .i_fault_en(fault_en),
    .i_fault_addr(fault_addr), .o_ready(ready), .o_rdata(rdata),
    .o_fault(fault));
  always #5 clk = ~clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (e !== g) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one load: reference result, issue, then follow the answers
  task automatic ld(input logic [5:0] op, input logic [4:0] rd,
      input logic isel, input logic [31:0] a);
    logic [3:0] et, gt;
    logic [31:0] w, d;
    logic [38:0] e;
    logic [12:0] imm;
    logic [7:0] easi;
    logic [1:0] fl;
    logic alt, flt, legal;
    int sz;
    imm = 13'(xs());
    src2 = xs();
    src1 = a - (isel ? {{19{imm[12]}}, imm} : src2);
    instr = {2'h3, rd, op, 5'(xs()), isel, isel ? imm : 13'(xs())};
    alt = op[5:4] == 2'h1;
    flt = op[5:4] == 2'h2;
    fl = flt ? (op == 6'h21 ? 2'h2 : 2'h1) : 2'h0;
    easi = alt ? instr[12:5] : (sup ? 8'h0B : 8'h0A);
    sz = op[1:0] == 2'h3 ? 8 : op[1:0] == 2'h2 ? 2 : op[1:0] == 2'h1 && !flt;
    if (sz == 0) sz = 4;
    legal = 1'b0;
    for (int i = 0; i < 18; i++) legal |= ops[i] == op;
    if (!legal || (alt && isel)) et = lu_pkg::TRAP_ILLEGAL;
    else if (alt && !sup) et = lu_pkg::TRAP_PRIV;
    else if (flt && !(fen && fpres)) et = lu_pkg::TRAP_FP_DIS;
    else if (op[5:4] == 2'h3) et = lu_pkg::TRAP_CP_DIS;
    else if (sz == 8 && rd[0]) et = flt ? 4'h5 : lu_pkg::TRAP_ILLEGAL;
    else if ((a & (sz - 1)) != 0) et = lu_pkg::TRAP_MISALIGN;
    else et = lu_pkg::TRAP_NONE;
    for (int k = 0; k < sz / 4 + 1 && k < 2 && et == 4'h0; k++) begin
      w = {a[31:2] + 30'(k), 2'h0} * 32'h00009E37 + 32'h1357;
      d = w;
      if (sz == 1) d = w >> ((3 - a[1:0]) * 8);
      if (sz == 1) d = op[3] ? {{24{d[7]}}, d[7:0]} : {24'h0, d[7:0]};
      if (sz == 2) d = w >> ((1 - a[1]) * 16);
      if (sz == 2) d = op[3] ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
      if (fault_en && a[31:2] + 30'(k) == fault_addr[31:2]) begin
        et = lu_pkg::TRAP_DATA_EXC;
        if (flt) expq.push_back({fl, rd | 5'(k), lu_pkg::FLOAT_FAULT_FILL});
      end else expq.push_back({fl, rd | 5'(k), d});
      if (sz != 8) break;
    end
    gt = 4'hF;
    issue = 1'b1;
    for (int c = 0; c < 60; c++) begin
      @(posedge clk);
      #1;
      issue = 1'b0;
      if (c == 4) fbusy = 1'b0;
      if (mvalid) chk("space", easi, req.asi);
      if (wbv) begin
        e = expq.size() ? expq.pop_front() : '1;
        if (e[38:37] == 2'h2) e[36:32] = wb.num;
        chk("wb", e, wb);
      end
      if (trapv || done) begin
        gt = trapv ? tcode : lu_pkg::TRAP_NONE;
        break;
      end
    end
    chk("trap", et, gt);
    chk("unseen wb", 0, expq.size());
    if (et == 4'h5) chk("ftt", 3'h6, ftt);
    expq.delete();
  endtask
  initial begin
    logic [31:0] a;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int p = 0; p < 3; p++) begin
      sup = p == 0;
      foreach (ops[i]) begin
        slow = 1'(xs());
        a = xs() & (p == 0 ? 32'h0000FFF8 : 32'h0000FFFF);
        ld(ops[i], 5'(4 * p), p == 1, a);
      end
    end
    sup = 1'b1;
    ld(6'h03, 5'h05, 1'b0, 32'h00000100);
    ld(6'h23, 5'h07, 1'b0, 32'h00000108);
    fen = 1'b0;
    ld(6'h20, 5'h02, 1'b0, 32'h00000010);
    fen = 1'b1;
    fpres = 1'b0;
    ld(6'h23, 5'h02, 1'b0, 32'h00000010);
    fpres = 1'b1;
    fbusy = 1'b1;
    ld(6'h21, 5'h00, 1'b0, 32'h00000020);
    @(posedge clk);
    #1;
    chk("fcc", 1, fccu);
    repeat (3) ld(6'h01, 5'h06, 1'b1, 32'h00000031);
    chk("fcc", 0, fccu);
    fault_en = 1'b1;
    fault_addr = 32'h00000204;
    ld(6'h03, 5'h08, 1'b0, 32'h00000200);
    fault_addr = 32'h00000300;
    ld(6'h20, 5'h03, 1'b1, 32'h00000300);
    fault_en = 1'b0;
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk("busy", 0, busy);
    ld(6'h23, 5'h04, 1'b0, 32'h00000408);
    results();
  end
  // hang guard
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
